/* rocs_pkg.sv */
// Package for the residual overcurrent stage: register map, timing constants, carriers
package rocs_pkg;
  localparam int MAG_W = 20;
  localparam int CLK_MHZ = 200;
  localparam int EVAL_PERIOD_MS = 5;
  localparam int PRETRIG_MS = 20;
  localparam int PREFAULT_MS = 200;
  localparam int PRETRIG_TICKS = PRETRIG_MS / EVAL_PERIOD_MS;
  localparam int PREFAULT_TICKS = PREFAULT_MS / EVAL_PERIOD_MS;
  localparam int HIST_DEPTH = PREFAULT_TICKS + 1;
  localparam int REC_DEPTH = 12;
  localparam int RESET_RATIO_PCT = 97;
  localparam int RATIO_MAX = 125000;
  localparam int TIME_MAX_TICKS = 360000;
  localparam int ANGLE_FULL = 36000;
  localparam int ANGLE_FWD = 9000;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_THRESH = 8'h04;
  localparam logic [7:0] REG_TRIP_DLY = 8'h08;
  localparam logic [7:0] REG_RST_DLY = 8'h0c;
  localparam logic [7:0] REG_INRUSH = 8'h10;
  localparam logic [7:0] REG_GROUP = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_RATIO = 8'h1c;
  localparam logic [7:0] REG_ANGLE = 8'h20;
  localparam logic [7:0] REG_REMAIN = 8'h24;
  localparam logic [7:0] REG_EXPECT = 8'h28;
  localparam logic [7:0] REG_CNT_ST = 8'h2c;
  localparam logic [7:0] REG_CNT_BLK = 8'h30;
  localparam logic [7:0] REG_REC_SEL = 8'h34;
  localparam logic [7:0] REG_REC_TS = 8'h38;
  localparam logic [7:0] REG_REC_INFO = 8'h3c;
  localparam logic [7:0] REG_REC_PRE = 8'h40;
  localparam logic [7:0] REG_REC_FLT = 8'h44;
  localparam logic [7:0] REG_REC_PREF = 8'h48;
  localparam logic [7:0] REG_REC_REM = 8'h4c;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_7e00;
  localparam logic [31:0] THRESH_RST = 32'h0000_2ee0;
  localparam logic [31:0] TRIP_DLY_RST = 32'h0000_0014;
  localparam logic [31:0] RST_DLY_RST = 32'h0000_0000;
  localparam logic [31:0] INRUSH_RST = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ROCS_NORMAL, ROCS_START, ROCS_TRIP, ROCS_BLOCKED} rocs_cond_t;

  typedef struct packed {
    logic tick;
    logic [MAG_W-1:0] coarse_fund;
    logic [MAG_W-1:0] coarse_trms;
    logic [MAG_W-1:0] coarse_pp;
    logic [MAG_W-1:0] sens_fund;
    logic [MAG_W-1:0] sens_trms;
    logic [MAG_W-1:0] sens_pp;
    logic [MAG_W-1:0] calc_fund;
    logic [15:0] harm2_ratio;
    logic signed [16:0] res_angle;
    logic signed [16:0] v1_angle;
    logic signed [16:0] i1_angle;
    logic volt_avail;
    logic [1:0] fault_phase;
    logic [31:0] timestamp;
  } rocs_meas_t;

  typedef struct packed {
    logic [1:0] stage;
    logic [5:0] flags;
    logic [31:0] timestamp;
  } rocs_event_t;
endpackage : rocs_pkg

/* rocs_stage.sv */
// Residual overcurrent stage: pick-up, block, timing, events, records and AXI4-Lite registers
// Function
// - Pick-up sets when selected magnitude exceeds the threshold.
// - Pick-up releases only below 97 % of the threshold.
// - One threshold serves every monitored channel alike.
// - Setting changes act live without stopping or resetting the stage.
// - Block input is sampled once per evaluation cycle and held.
// - Pick-up without block raises start and starts trip timing.
// - Pick-up with block raises blocked, no start or trip.
// - Block after start clears start and runs release timing.
// - Optional second-harmonic inrush block, off by default, limit in 0.01 %.
// - Definite-time and inverse-time trip characteristics; definite-time reset only.
// - On/off events for start, trip, block, each selectable.
// - Clearable cumulative counters for start, trip and blocked.
// - Two-bit STAGE_ID gives up to four instances each its own event identity.
// - Twelve newest records, oldest overwritten, written on on-events only.
// - Record holds time, event, fault type, currents, remaining time, group.
// - Last fault classed by phase and direction, six codes plus none.
// - Residual angle in 0.01 deg against U1, else I1 reference.
// - Remaining trip time shown in 5 ms steps.
// - Inverse-time expected time follows the measured current.
// - Live current-to-threshold ratio in 0.01 steps and stage condition.
// - Input selectable among two measured and one calculated residual.
// - New magnitude every 5 ms; stage evaluated on that period.
// - Forcing overrides the condition to normal, start, trip or blocked.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module rocs_stage
  import rocs_pkg::*;
#(
  parameter logic [1:0] STAGE_ID = 2'h0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rocs_meas_t meas,
  input wire logic block_in,
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic ev_valid,
  output rocs_event_t ev
);

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction : strb_merge

  function automatic logic [31:0] sat_div(input logic [31:0] num, input logic [31:0] den, input logic [31:0] lim);
    logic [31:0] q;
    q = (den == 32'h0) ? lim : num / den;
    return (q > lim) ? lim : q;
  endfunction : sat_div

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus slave
  logic [31:0] ctrl, thresh, trip_dly, rst_dly, inrush, group, rec_sel;
  logic aw_hold, w_hold, cnt_clr;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;
  logic [31:0] rd_mux;
  logic wr_map;

  always_comb begin
    wr_map = aw_q inside {REG_CTRL, REG_THRESH, REG_TRIP_DLY, REG_RST_DLY, REG_INRUSH, REG_GROUP, REG_REC_SEL};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      s_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_hold && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_q <= s_axi_wdata;
        s_q <= s_axi_wstrb;
      end
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Settings are used straight from these registers, so a setting change acts on the next evaluation; group is only stored into records
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RST;
      thresh <= THRESH_RST;
      trip_dly <= TRIP_DLY_RST;
      rst_dly <= RST_DLY_RST;
      inrush <= INRUSH_RST;
      group <= 32'h0;
      rec_sel <= 32'h0;
      cnt_clr <= 1'b0;
    end else begin
      cnt_clr <= 1'b0;
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        case (aw_q)
          REG_CTRL: begin
            ctrl <= strb_merge(ctrl, w_q, s_q) & 32'h0000_7fff;
            cnt_clr <= s_q[1] && w_q[15];
          end
          REG_THRESH: thresh <= strb_merge(thresh, w_q, s_q) & 32'h000f_ffff;
          REG_TRIP_DLY: trip_dly <= strb_merge(trip_dly, w_q, s_q);
          REG_RST_DLY: rst_dly <= strb_merge(rst_dly, w_q, s_q);
          REG_INRUSH: inrush <= strb_merge(inrush, w_q, s_q) & 32'h0000_ffff;
          REG_GROUP: group <= strb_merge(group, w_q, s_q) & 32'h0000_0007;
          REG_REC_SEL: rec_sel <= strb_merge(rec_sel, w_q, s_q) & 32'h0000_000f;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement selection, pick-up and block
  logic [MAG_W-1:0] mag;
  logic [31:0] ratio, expect_t, elapsed, rst_cnt;
  logic pickup, next_pickup, cyc_blk, blk_smp, inrush_blk;

  always_comb begin
    case ({ctrl[3:2], ctrl[5:4]})
      4'h0: mag = meas.coarse_fund;
      4'h1: mag = meas.coarse_trms;
      4'h2: mag = meas.coarse_pp;
      4'h4: mag = meas.sens_fund;
      4'h5: mag = meas.sens_trms;
      4'h6: mag = meas.sens_pp;
      default: mag = meas.calc_fund;
    endcase
    // A single threshold compare; every selectable channel meets the same value
    next_pickup = pickup;
    if (32'(mag) > thresh) next_pickup = 1'b1;
    else if (32'(mag) * 32'd100 < thresh * 32'(RESET_RATIO_PCT)) next_pickup = 1'b0;
    inrush_blk = ctrl[0] && (32'(meas.harm2_ratio) > inrush);
    cyc_blk = block_in || inrush_blk;
    ratio = sat_div(32'(mag) * 32'd100, thresh, 32'(RATIO_MAX));
    // Inverse time: multiplier over excess ratio, re-evaluated every period
    if (ctrl[1]) expect_t = sat_div(trip_dly * 32'd100, (ratio > 32'd100) ? ratio - 32'd100 : 32'd0,
                                    32'(TIME_MAX_TICKS));
    else expect_t = trip_dly;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pickup <= 1'b0;
      blk_smp <= 1'b0;
    end else if (meas.tick) begin
      pickup <= next_pickup;
      blk_smp <= cyc_blk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage sequencing
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_TRIP, ST_BLOCKED, ST_RELEASE} rocs_state_t;
  rocs_state_t state;
  logic hold_start, hold_trip;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      elapsed <= 32'h0;
      rst_cnt <= 32'h0;
      hold_start <= 1'b0;
      hold_trip <= 1'b0;
    end else if (meas.tick) begin
      case (state)
        ST_IDLE: begin
          elapsed <= 32'h0;
          if (next_pickup && cyc_blk) state <= ST_BLOCKED;
          else if (next_pickup) state <= ST_START;
        end
        ST_START, ST_TRIP: begin
          rst_cnt <= 32'h0;
          if (!next_pickup || cyc_blk) begin
            state <= ST_RELEASE;
            hold_start <= !cyc_blk;
            hold_trip <= !cyc_blk && (state == ST_TRIP);
          end else if (state == ST_START) begin
            elapsed <= elapsed + 32'h1;
            if (elapsed + 32'h1 >= expect_t) state <= ST_TRIP;
          end
        end
        ST_BLOCKED: begin
          if (!next_pickup) state <= ST_IDLE;
          else if (!cyc_blk) state <= ST_START;
        end
        ST_RELEASE: begin
          if (next_pickup && !cyc_blk) begin
            state <= hold_trip ? ST_TRIP : ST_START;
          end else if (rst_cnt + 32'h1 >= rst_dly) begin
            state <= ST_IDLE;
            hold_start <= 1'b0;
            hold_trip <= 1'b0;
          end else begin
            rst_cnt <= rst_cnt + 32'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Condition and outputs; forcing overrides what the sequencer computed
  rocs_cond_t cond, next_cond;
  always_comb begin
    case (state)
      ST_START: next_cond = ROCS_START;
      ST_TRIP: next_cond = ROCS_TRIP;
      ST_BLOCKED: next_cond = ROCS_BLOCKED;
      ST_RELEASE: next_cond = hold_trip ? ROCS_TRIP : (hold_start ? ROCS_START : ROCS_NORMAL);
      default: next_cond = ROCS_NORMAL;
    endcase
    if (ctrl[6]) next_cond = rocs_cond_t'(ctrl[8:7]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond <= ROCS_NORMAL;
      start_out <= 1'b0;
      trip_out <= 1'b0;
      blocked_out <= 1'b0;
    end else begin
      cond <= next_cond;
      start_out <= next_cond == ROCS_START || next_cond == ROCS_TRIP;
      trip_out <= next_cond == ROCS_TRIP;
      blocked_out <= next_cond == ROCS_BLOCKED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Angle, fault type, remaining time
  logic signed [17:0] ang_raw, angle;
  logic [2:0] ftype, next_ftype;
  logic [31:0] remain;

  always_comb begin
    ang_raw = 18'(meas.res_angle) - 18'(meas.volt_avail ? meas.v1_angle : meas.i1_angle);
    if (ang_raw > 18'sd36000) angle = ang_raw - 18'sd36000;
    else if (ang_raw < -18'sd36000) angle = ang_raw + 18'sd36000;
    else angle = ang_raw;
    // Codes 1..6: A-R, B-F, C-R, A-F, B-R, C-F; 0 is no fault
    case ({meas.fault_phase, (angle <= 18'(ANGLE_FWD)) && (angle >= -18'(ANGLE_FWD))})
      3'b010: next_ftype = 3'h1;
      3'b101: next_ftype = 3'h2;
      3'b110: next_ftype = 3'h3;
      3'b011: next_ftype = 3'h4;
      3'b100: next_ftype = 3'h5;
      3'b111: next_ftype = 3'h6;
      default: next_ftype = 3'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ftype <= 3'h0;
      remain <= 32'h0;
    end else begin
      if (meas.tick && state == ST_IDLE && next_pickup) ftype <= next_ftype;
      // One count is one 5 ms evaluation period
      remain <= (state == ST_START && expect_t > elapsed) ? expect_t - elapsed : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events, counters, history and records
  logic start_q, trip_q, blk_q;
  logic [5:0] ev_raw;
  logic [15:0] cnt_start, cnt_trip, cnt_blk;
  logic [MAG_W-1:0] hist [HIST_DEPTH];
  logic [MAG_W-1:0] prefault;
  logic [3:0] wr_ptr;
  logic [31:0] rec_ts [REC_DEPTH];
  logic [31:0] rec_info [REC_DEPTH];
  logic [MAG_W-1:0] rec_pre [REC_DEPTH];
  logic [MAG_W-1:0] rec_flt [REC_DEPTH];
  logic [MAG_W-1:0] rec_pref [REC_DEPTH];
  logic [31:0] rec_rem [REC_DEPTH];

  always_comb begin
    ev_raw = {blocked_out & !blk_q, !blocked_out & blk_q, trip_out & !trip_q, !trip_out & trip_q,
              start_out & !start_q, !start_out & start_q};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
      trip_q <= 1'b0;
      blk_q <= 1'b0;
      ev_valid <= 1'b0;
      ev <= '0;
    end else begin
      start_q <= start_out;
      trip_q <= trip_out;
      blk_q <= blocked_out;
      ev_valid <= |(ev_raw & ctrl[14:9]);
      ev <= '{stage: STAGE_ID, flags: ev_raw & ctrl[14:9], timestamp: meas.timestamp};
    end
  end

  // Increment after clear, so an occurrence in the clear cycle is still counted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_start <= 16'h0;
      cnt_trip <= 16'h0;
      cnt_blk <= 16'h0;
    end else begin
      cnt_start <= (cnt_clr ? 16'h0 : cnt_start) + 16'(ev_raw[1]);
      cnt_trip <= (cnt_clr ? 16'h0 : cnt_trip) + 16'(ev_raw[3]);
      cnt_blk <= (cnt_clr ? 16'h0 : cnt_blk) + 16'(ev_raw[5]);
    end
  end

  always_ff @(posedge aclk) begin
    if (meas.tick) begin
      hist[0] <= mag;
      for (int i = 1; i < HIST_DEPTH; i++) begin
        hist[i] <= hist[i-1];
      end
    end
  end

  // Record only on-edges; the ring pointer wraps so the oldest entry is overwritten
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= 4'h0;
      prefault <= '0;
    end else begin
      if (ev_raw[1]) prefault <= hist[PREFAULT_TICKS-1];
      if (ev_raw[1] || ev_raw[3] || ev_raw[5]) begin
        wr_ptr <= (wr_ptr == 4'(REC_DEPTH - 1)) ? 4'h0 : wr_ptr + 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (ev_raw[1] || ev_raw[3] || ev_raw[5]) begin
      rec_ts[wr_ptr] <= meas.timestamp;
      rec_info[wr_ptr] <= {22'h0, group[2:0], ftype, ev_raw[5], ev_raw[3], ev_raw[1], 1'b0};
      rec_pre[wr_ptr] <= hist[PRETRIG_TICKS-1];
      rec_flt[wr_ptr] <= hist[0];
      rec_pref[wr_ptr] <= ev_raw[1] ? hist[PREFAULT_TICKS-1] : prefault;
      rec_rem[wr_ptr] <= remain;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  always_comb begin
    case (s_axi_araddr)
      REG_CTRL: rd_mux = ctrl;
      REG_THRESH: rd_mux = thresh;
      REG_TRIP_DLY: rd_mux = trip_dly;
      REG_RST_DLY: rd_mux = rst_dly;
      REG_INRUSH: rd_mux = inrush;
      REG_GROUP: rd_mux = group;
      REG_STATUS: rd_mux = {24'h0, blk_smp, pickup, ftype, 1'b0, cond};
      REG_RATIO: rd_mux = ratio;
      REG_ANGLE: rd_mux = 32'(angle);
      REG_REMAIN: rd_mux = remain;
      REG_EXPECT: rd_mux = expect_t;
      REG_CNT_ST: rd_mux = {cnt_trip, cnt_start};
      REG_CNT_BLK: rd_mux = {16'h0, cnt_blk};
      REG_REC_SEL: rd_mux = {28'h0, wr_ptr} << 16 | rec_sel;
      REG_REC_TS: rd_mux = rec_ts[rec_sel[3:0] % 4'(REC_DEPTH)];
      REG_REC_INFO: rd_mux = rec_info[rec_sel[3:0] % 4'(REC_DEPTH)];
      REG_REC_PRE: rd_mux = 32'(rec_pre[rec_sel[3:0] % 4'(REC_DEPTH)]);
      REG_REC_FLT: rd_mux = 32'(rec_flt[rec_sel[3:0] % 4'(REC_DEPTH)]);
      REG_REC_PREF: rd_mux = 32'(rec_pref[rec_sel[3:0] % 4'(REC_DEPTH)]);
      REG_REC_REM: rd_mux = rec_rem[rec_sel[3:0] % 4'(REC_DEPTH)];
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= (s_axi_araddr > REG_REC_REM || s_axi_araddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  pickup_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    meas.tick && 32'(mag) > thresh |=> pickup) else $error("pick-up not set above threshold");
  pickup_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    meas.tick && pickup && 32'(mag) * 32'd100 >= thresh * 32'd97 |=> pickup)
    else $error("pick-up released above reset ratio");
  start_go_a: assert property (@(posedge aclk) disable iff (!aresetn)
    meas.tick && state == ST_IDLE && next_pickup && !cyc_blk && !ctrl[6] |=> ##1 start_out && !blocked_out)
    else $error("start not raised on unblocked pick-up");
  block_go_a: assert property (@(posedge aclk) disable iff (!aresetn)
    meas.tick && state == ST_IDLE && next_pickup && cyc_blk && !ctrl[6] |=> ##1 blocked_out && !start_out)
    else $error("blocked not raised on blocked pick-up");
  block_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    meas.tick && state == ST_START && next_pickup && cyc_blk && !ctrl[6] |=> ##1 !start_out)
    else $error("start kept after block");
  trip_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
    trip_out && !$past(trip_out) && !ctrl[6] && !$past(ctrl[6]) |-> $past(state, 2) == ST_START || $past(state, 2) == ST_RELEASE)
    else $error("trip without preceding start");
  force_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl[6] |=> cond == rocs_cond_t'($past(ctrl[8:7]))) else $error("forced condition not applied");
  rec_ptr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ev_raw[1] || ev_raw[3] || ev_raw[5]) && wr_ptr == 4'd11 |=> wr_ptr == 4'd0)
    else $error("record ring did not wrap at twelve");
  count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_raw[1] && !cnt_clr |=> cnt_start == $past(cnt_start) + 16'h1) else $error("start count missed");
  remain_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state != ST_START |=> remain == 32'h0) else $error("remaining time outside countdown");
endmodule : rocs_stage

/* rocs_src.sv */
// Partner model: measurement feed and blocking matrix input for the stage
`timescale 1ns/10ps
module rocs_src
  import rocs_pkg::*;
#(
  parameter int TP = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [MAG_W-1:0] mag,
  input wire logic blk,
  output rocs_meas_t meas,
  output logic block_in
);
  int cnt = 0;
  initial meas = '0;
  initial block_in = 1'b0;
  ////////////////////////////////////////////////////////////////
  // Short tick spacing keeps the run brief; the stage only needs two cycles
  always @(posedge aclk) begin
    cnt <= (!aresetn || cnt == TP - 1) ? 0 : cnt + 1;
    meas.tick <= aresetn && cnt == TP - 1;
    meas.coarse_fund <= mag;
    meas.fault_phase <= 2'h1;
    meas.timestamp <= meas.timestamp + 32'h1;
    block_in <= blk;
  end
endmodule : rocs_src

/* rocs_stage_test.sv */
// Self-checking testbench for the residual overcurrent stage
`timescale 1ns/10ps
module rocs_stage_test;
  import rocs_pkg::*;
  localparam int TP = 8;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, blk = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awready, wready, bvalid, arready, rvalid, start_out, trip_out, blocked_out, ev_valid, block_in;
  logic [1:0] bresp, rresp;
  logic [MAG_W-1:0] mag = 0;
  rocs_meas_t meas;
  rocs_event_t ev;
  logic [7:0] evq[$];
  int err_count = 0, tests_run = 0, seed = 32'h1af3db50;
  always #2.5 aclk = ~aclk;
  rocs_stage #(.STAGE_ID(2'h2)) rocs_stage_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .meas(meas), .block_in(block_in), .start_out(start_out),
    .trip_out(trip_out), .blocked_out(blocked_out), .ev_valid(ev_valid), .ev(ev));
  rocs_src #(.TP(TP)) rocs_src_i (.aclk(aclk), .aresetn(aresetn), .mag(mag), .blk(blk),
    .meas(meas), .block_in(block_in));
  ////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task hang;
    err_count++;
    report_and_stop();
  endtask : hang
  // Ready is looked at mid-cycle so the handshake edge is judged without a race
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw, w, b;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 99 && !b; n++) begin
      @(negedge aclk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 0;
      if (w) wvalid <= 0;
    end
    bready <= 0;
    // Let an edge pass so a following call never reassigns bready in the same step
    @(posedge aclk);
    if (!b) hang();
    cmp(32'(r), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ar, v;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 99 && !v; n++) begin
      @(negedge aclk);
      ar = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 0;
    end
    rready <= 0;
    @(posedge aclk);
    if (!v) hang();
    cmp(32'(r), 32'(er));
    cmp(d, ed);
  endtask : rd
  task tk(input int n);
    repeat (n * TP) @(posedge aclk);
  endtask : tk
  ////////////////////////////////////////////////////////////////
  always @(negedge aclk) begin
    // An event with nothing expected is a mismatch, not something to skip
    if (ev_valid === 1'b1)
      cmp(32'({ev.stage, ev.flags}), evq.size() > 0 ? 32'(evq.pop_front()) : 32'hffff_ffff);
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(REG_CTRL, CTRL_RST, RESP_OKAY);
    rd(REG_THRESH, THRESH_RST, RESP_OKAY);
    rd(REG_INRUSH, INRUSH_RST, RESP_OKAY);
    rd(8'h50, 32'h0, RESP_SLVERR);
    wr(8'h50, 32'h0, RESP_SLVERR);
    $display("end registers");
    wr(REG_THRESH, 32'h3e8, RESP_OKAY);
    wr(REG_TRIP_DLY, 32'hc8, RESP_OKAY);
    mag <= 20'h3e8;
    tk(3);
    cmp(32'(start_out), 0);
    evq.push_back({2'h2, 6'h02});
    mag <= 20'h3e9;
    tk(3);
    cmp(32'(start_out), 1);
    mag <= 20'h3ca;
    tk(3);
    cmp(32'(start_out), 1);
    evq.push_back({2'h2, 6'h08});
    wr(REG_TRIP_DLY, 32'h2, RESP_OKAY);
    tk(3);
    cmp(32'(trip_out), 1);
    evq.push_back({2'h2, 6'h05});
    mag <= 20'h3c9;
    tk(3);
    cmp(32'({start_out, trip_out}), 0);
    $display("end hysteresis");
    wr(REG_TRIP_DLY, 32'hc8, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      evq.push_back({2'h2, 6'h02});
      evq.push_back({2'h2, 6'h01});
      mag <= 20'h3e9 + 20'($random(seed) & 32'hfff);
      tk(3);
      cmp(32'(start_out), 1);
      mag <= 20'($random(seed) & 32'h1ff);
      tk(3);
    end
    rd(REG_CNT_ST, 32'h0001_0004, RESP_OKAY);
    wr(REG_CTRL, CTRL_RST | 32'h8000, RESP_OKAY);
    rd(REG_CNT_ST, 32'h0, RESP_OKAY);
    $display("end counters");
    blk <= 1;
    tk(1);
    evq.push_back({2'h2, 6'h20});
    mag <= 20'h7d0;
    tk(3);
    cmp(32'(blocked_out), 1);
    cmp(32'(start_out), 0);
    evq.push_back({2'h2, 6'h10});
    mag <= 0;
    tk(3);
    blk <= 0;
    tk(3);
    evq.push_back({2'h2, 6'h02});
    mag <= 20'h7d0;
    tk(3);
    // Block drops start, release runs out, then the still-present pick-up is seen as blocked
    evq.push_back({2'h2, 6'h01});
    evq.push_back({2'h2, 6'h20});
    blk <= 1;
    tk(4);
    cmp(32'({start_out, trip_out, blocked_out}), 1);
    evq.push_back({2'h2, 6'h10});
    mag <= 0;
    blk <= 0;
    tk(4);
    cmp(32'(evq.size()), 0);
    $display("end blocking");
    evq.push_back({2'h2, 6'h0a});
    wr(REG_CTRL, CTRL_RST | 32'h0140, RESP_OKAY);
    tk(1);
    cmp(32'({start_out, trip_out, blocked_out}), 32'h6);
    rd(REG_STATUS, 32'h22, RESP_OKAY);
    evq.push_back({2'h2, 6'h05});
    wr(REG_CTRL, CTRL_RST, RESP_OKAY);
    tk(1);
    rd(REG_REC_SEL, 32'h0009_0000, RESP_OKAY);
    rd(REG_REC_INFO, 32'h42, RESP_OKAY);
    cmp(32'(evq.size()), 0);
    $display("end forcing");
    report_and_stop();
  end
endmodule : rocs_stage_test
